// File: design/fsfwg_host.sv
// Host controller: APB registers, flash bus cycles and status polling
module fsfwg_host (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output fsfwg_pkg::fsfwg_pins_t flash_o,
	input wire logic [fsfwg_pkg::DATA_W-1:0] dq_i
);

	typedef enum {C_IDLE, C_SET, C_STB, C_REC} fsfwg_phase_t;
	typedef enum {S_IDLE, S_WR, S_RD, S_P1, S_P2, S_P3, S_P4, S_CK1, S_CKW, S_CK2,
		S_RST} fsfwg_seq_t;

	// ==========================================
	// Input synchroniser
	logic [fsfwg_pkg::DATA_W-1:0] dq_s1_q;
	logic [fsfwg_pkg::DATA_W-1:0] dq_s2_q;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	// ==========================================
	// APB slave
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [fsfwg_pkg::ADDR_W-1:0] addr_q;
	logic [fsfwg_pkg::DATA_W-1:0] wdata_q;
	logic [fsfwg_pkg::DATA_W-1:0] rdata_q;
	logic [2:0] op_q;
	logic stop_q;
	logic done_q;
	logic fail_q;
	logic abort_q;
	logic win_after_q;
	logic win_before_q;
	logic stopped_q;
	fsfwg_seq_t seq_q;

	wire acc = psel & penable & ~pready_q;
	wire wr_take = psel & penable & pready_q & pwrite;
	wire sel_ctrl = (paddr == fsfwg_pkg::OFF_CTRL);
	wire sel_addr = (paddr == fsfwg_pkg::OFF_ADDR);
	wire sel_wdata = (paddr == fsfwg_pkg::OFF_WDATA);
	wire sel_rdata = (paddr == fsfwg_pkg::OFF_RDATA);
	wire sel_status = (paddr == fsfwg_pkg::OFF_STATUS);
	wire hit = sel_ctrl | sel_addr | sel_wdata | sel_rdata | sel_status;
	wire seq_idle = (seq_q == S_IDLE);
	wire start = wr_take & sel_ctrl & pwdata[fsfwg_pkg::CTRL_GO] & seq_idle;
	wire stop_req = wr_take & sel_ctrl & pwdata[fsfwg_pkg::CTRL_STOP];
	wire done_clr = wr_take & sel_status & pwdata[fsfwg_pkg::ST_DONE];

	logic [31:0] status_w;
	always_comb begin
		status_w = '0;
		status_w[fsfwg_pkg::ST_BUSY] = ~seq_idle;
		status_w[fsfwg_pkg::ST_DONE] = done_q;
		status_w[fsfwg_pkg::ST_FAIL] = fail_q;
		status_w[fsfwg_pkg::ST_ABORT] = abort_q;
		status_w[fsfwg_pkg::ST_WIN_AFTER] = win_after_q;
		status_w[fsfwg_pkg::ST_STOPPED] = stopped_q;
		status_w[fsfwg_pkg::ST_WIN_BEFORE] = win_before_q;
	end

	wire [31:0] rd_mux = sel_ctrl ? {26'h0, stop_q, 2'h0, op_q} :
		sel_addr ? {10'h0, addr_q} :
		sel_wdata ? {16'h0, wdata_q} :
		sel_rdata ? {16'h0, rdata_q} :
		sel_status ? status_w : 32'h0000_0000;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc & ~hit;
			if (acc) begin
				prdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			addr_q <= '0;
			wdata_q <= '0;
			op_q <= fsfwg_pkg::OP_WRITE;
		end else begin
			if (wr_take & sel_addr & seq_idle) begin
				addr_q <= pwdata[fsfwg_pkg::ADDR_W-1:0];
			end
			if (wr_take & sel_wdata & seq_idle) begin
				wdata_q <= pwdata[fsfwg_pkg::DATA_W-1:0];
			end
			if (start) begin
				op_q <= pwdata[fsfwg_pkg::CTRL_OP_LSB +: fsfwg_pkg::CTRL_OP_W];
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ==========================================
	// Bus cycle engine
	fsfwg_phase_t phase_q;
	fsfwg_pkg::fsfwg_pins_t pins_q;
	logic [7:0] cnt_q;
	logic wr_q;
	logic cyc_done_q;
	logic [fsfwg_pkg::DATA_W-1:0] cap_q;
	logic [1:0] step_q;
	logic rst_abort_q;

	wire bus_state = ~seq_idle;
	wire cyc_req = bus_state & (phase_q == C_IDLE) & ~cyc_done_q;
	wire rst_state = (seq_q == S_RST);
	wire cyc_wr = (seq_q == S_WR) | (seq_q == S_CKW) | rst_state;
	wire [fsfwg_pkg::ADDR_W-1:0] rst_addr = ~rst_abort_q ? addr_q :
		(step_q == 2'h1) ? fsfwg_pkg::ADR_UNLOCK2 : fsfwg_pkg::ADR_UNLOCK1;
	wire [fsfwg_pkg::DATA_W-1:0] rst_data = ~rst_abort_q ? fsfwg_pkg::CMD_RESET :
		(step_q == 2'h0) ? fsfwg_pkg::CMD_UNLOCK1 :
		(step_q == 2'h1) ? fsfwg_pkg::CMD_UNLOCK2 : fsfwg_pkg::CMD_RESET;
	wire [fsfwg_pkg::ADDR_W-1:0] cyc_addr = rst_state ? rst_addr : addr_q;
	wire [fsfwg_pkg::DATA_W-1:0] cyc_data = rst_state ? rst_data : wdata_q;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			phase_q <= C_IDLE;
			// Strobes idle high from reset onward
			pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: '0,
				dq_oe_n: 1'b1};
			cnt_q <= '0;
			wr_q <= 1'b0;
			cyc_done_q <= 1'b0;
			cap_q <= '0;
		end else begin
			cyc_done_q <= 1'b0;
			case (phase_q)
			C_IDLE: begin
				if (cyc_req) begin
					pins_q.ce_n <= 1'b0;
					pins_q.addr <= cyc_addr;
					pins_q.dq_o <= cyc_data;
					pins_q.dq_oe_n <= ~cyc_wr;
					wr_q <= cyc_wr;
					phase_q <= C_SET;
				end
			end
			C_SET: begin
				// Write strobe only with select low and output enable high
				pins_q.we_n <= ~wr_q;
				pins_q.oe_n <= wr_q;
				cnt_q <= (wr_q ? fsfwg_pkg::WP_CYC : fsfwg_pkg::RD_CYC) - 8'h01;
				phase_q <= C_STB;
			end
			C_STB: begin
				if (cnt_q == 8'h00) begin
					pins_q.we_n <= 1'b1;
					pins_q.oe_n <= 1'b1;
					pins_q.ce_n <= 1'b1;
					if (!wr_q) begin
						cap_q <= dq_s2_q;
					end
					cnt_q <= fsfwg_pkg::REC_CYC - 8'h01;
					phase_q <= C_REC;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
			C_REC: begin
				if (cnt_q == 8'h00) begin
					pins_q.dq_oe_n <= 1'b1;
					cyc_done_q <= 1'b1;
					phase_q <= C_IDLE;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
			default: phase_q <= C_IDLE;
			endcase
		end
	end

	assign flash_o = pins_q;

	// ==========================================
	// Operation sequencer
	logic [fsfwg_pkg::DATA_W-1:0] first_q;
	logic finish;
	logic stopped_set;

	wire tgl_same = (cap_q[fsfwg_pkg::BIT_BUSY_TGL] == first_q[fsfwg_pkg::BIT_BUSY_TGL]);

	always_comb begin
		finish = 1'b0;
		stopped_set = 1'b0;
		if (cyc_done_q) begin
			case (seq_q)
			S_WR, S_RD, S_CK2: finish = 1'b1;
			S_P2: begin
				finish = tgl_same | (stop_q & ~cap_q[fsfwg_pkg::BIT_BUF_ABORT]
					& ~cap_q[fsfwg_pkg::BIT_TIMEOUT]);
				stopped_set = ~tgl_same & stop_q & ~cap_q[fsfwg_pkg::BIT_BUF_ABORT]
					& ~cap_q[fsfwg_pkg::BIT_TIMEOUT];
			end
			S_P4: finish = tgl_same;
			S_RST: finish = ~rst_abort_q | (step_q == 2'h2);
			default: finish = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			seq_q <= S_IDLE;
			first_q <= '0;
			rdata_q <= '0;
			step_q <= '0;
			rst_abort_q <= 1'b0;
			stop_q <= 1'b0;
			fail_q <= 1'b0;
			abort_q <= 1'b0;
			win_after_q <= 1'b0;
			win_before_q <= 1'b0;
			stopped_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			// Completion beats a same-cycle clear
			done_q <= finish | (done_q & ~done_clr);
			stop_q <= stop_req & ~seq_idle | (stop_q & ~seq_idle & ~start);
			if (stopped_set) begin
				stopped_q <= 1'b1;
			end
			if (start) begin
				fail_q <= 1'b0;
				abort_q <= 1'b0;
				stopped_q <= 1'b0;
				case (pwdata[fsfwg_pkg::CTRL_OP_LSB +: fsfwg_pkg::CTRL_OP_W])
				fsfwg_pkg::OP_WRITE: seq_q <= S_WR;
				fsfwg_pkg::OP_READ: seq_q <= S_RD;
				// Every poll begins at its first read
				fsfwg_pkg::OP_POLL: seq_q <= S_P1;
				fsfwg_pkg::OP_ERASE_ADD: seq_q <= S_CK1;
				default: seq_q <= S_IDLE;
				endcase
			end else if (finish) begin
				seq_q <= S_IDLE;
				if (seq_q != S_WR && seq_q != S_RST) begin
					rdata_q <= cap_q;
				end
			end else if (cyc_done_q) begin
				case (seq_q)
				S_P1: begin
					first_q <= cap_q;
					seq_q <= S_P2;
				end
				S_P2: begin
					rdata_q <= cap_q;
					if (cap_q[fsfwg_pkg::BIT_BUF_ABORT]) begin
						// Abort-reset sequence before array reads
						abort_q <= 1'b1;
						rst_abort_q <= 1'b1;
						step_q <= 2'h0;
						seq_q <= S_RST;
					end else if (cap_q[fsfwg_pkg::BIT_TIMEOUT]) begin
						// Timeout seen: read toggle twice more and compare
						seq_q <= S_P3;
					end else begin
						// Still toggling: poll again in pairs
						seq_q <= S_P1;
					end
				end
				S_P3: begin
					first_q <= cap_q;
					seq_q <= S_P4;
				end
				S_P4: begin
					// Still toggling after timeout: reset command
					rdata_q <= cap_q;
					fail_q <= 1'b1;
					rst_abort_q <= 1'b0;
					step_q <= 2'h0;
					seq_q <= S_RST;
				end
				S_CK1: begin
					// Window checked before and after the command
					win_before_q <= cap_q[fsfwg_pkg::BIT_WINDOW];
					seq_q <= S_CKW;
				end
				S_CKW: seq_q <= S_CK2;
				S_RST: step_q <= step_q + 2'h1;
				default: seq_q <= S_IDLE;
				endcase
			end
			if (cyc_done_q && seq_q == S_CK2) begin
				win_after_q <= cap_q[fsfwg_pkg::BIT_WINDOW];
			end
		end
	end

endmodule

// File: design/fsfwg_pkg.sv
// Constants, pin bundle and register map of the flash status polling host
//
// Behaviour
// - Host resets device after timeout flag
// - Host checks window before and after command
// - Host reads twice, compares toggle bits
// - Timeout seen: recheck toggle, fail means reset
// - Interrupted polling restarts from first step
// - Buffer abort flag needs abort-reset sequence
// - Write only with select, strobe low, output-enable high
package fsfwg_pkg;

	// ==========================================
	// Widths
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;

	// ==========================================
	// Register offsets (APB byte addresses)
	localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFF_ADDR = 32'h0000_0004;
	localparam logic [31:0] OFF_WDATA = 32'h0000_0008;
	localparam logic [31:0] OFF_RDATA = 32'h0000_000C;
	localparam logic [31:0] OFF_STATUS = 32'h0000_0010;

	// ==========================================
	// Control fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 3;
	localparam int CTRL_GO = 4;
	localparam int CTRL_STOP = 5;
	localparam logic [2:0] OP_WRITE = 3'h0;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_POLL = 3'h2;
	localparam logic [2:0] OP_ERASE_ADD = 3'h3;

	// ==========================================
	// Status fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_ABORT = 3;
	localparam int ST_WIN_AFTER = 4;
	localparam int ST_STOPPED = 5;
	localparam int ST_WIN_BEFORE = 6;

	// ==========================================
	// Status bit positions on the flash data bus
	localparam int BIT_BUSY_TGL = 6;
	localparam int BIT_TIMEOUT = 5;
	localparam int BIT_WINDOW = 3;
	localparam int BIT_BUF_ABORT = 1;

	// ==========================================
	// Command words and unlock addresses
	localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
	localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [ADDR_W-1:0] ADR_UNLOCK1 = 22'h00_0555;
	localparam logic [ADDR_W-1:0] ADR_UNLOCK2 = 22'h00_02AA;

	// ==========================================
	// Bus cycle timing
	localparam int CLK_NS = 10;
	localparam int T_ACC_NS = 100;
	localparam int T_WP_NS = 35;
	localparam int T_REC_NS = 20;
	localparam int SYNC_CYC = 2;
	localparam logic [7:0] RD_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
	localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] REC_CYC = 8'((T_REC_NS + CLK_NS - 1) / CLK_NS);

	// ==========================================
	// Flash pin bundle
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_o;
		logic dq_oe_n;
	} fsfwg_pins_t;

endpackage

// File: tb/fsfwg_checker.sv
// Port assertions for the flash status host
module fsfwg_checker (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input fsfwg_pkg::fsfwg_pins_t flash_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// ==========
	// Register bus
	property p_wait; $rose(penable) && psel |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("late bus answer");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("answer too long");
	property p_err; pslverr |-> pready && psel && penable; endproperty
	a_err: assert property (p_err) else $error("stray error");
	// ==========
	// Flash strobes
	property p_wr; !flash_o.we_n |-> !flash_o.ce_n && flash_o.oe_n && !flash_o.dq_oe_n; endproperty
	a_wr: assert property (p_wr) else $error("bad write strobe");
	property p_rd; !flash_o.oe_n |-> !flash_o.ce_n && flash_o.we_n && flash_o.dq_oe_n; endproperty
	a_rd: assert property (p_rd) else $error("bad read strobe");
	property p_wp; $fell(flash_o.we_n) |-> (!flash_o.we_n)[*4] ##1 flash_o.we_n; endproperty
	a_wp: assert property (p_wp) else $error("write pulse length");
	property p_acc;
		$fell(flash_o.oe_n) |-> (!flash_o.oe_n)[*8] ##1 (!flash_o.oe_n)[*4] ##1 flash_o.oe_n;
	endproperty
	a_acc: assert property (p_acc) else $error("read strobe length");
	property p_hold; !flash_o.ce_n && !$fell(flash_o.ce_n) |-> $stable(flash_o.addr); endproperty
	a_hold: assert property (p_hold) else $error("address moved");
endmodule

bind fsfwg_host fsfwg_checker u_chk (
	.mclk(mclk),
	.reset_n(reset_n),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.flash_o(flash_o)
);

// File: tb/fsfwg_flash_model.sv
// Flash device model answering the host's bus cycles
module fsfwg_flash_model (
	input fsfwg_pkg::fsfwg_pins_t pins,
	output logic [15:0] dq_i,
	input wire logic [2:0] mode,
	input wire logic [7:0] cnt,
	input wire logic arm,
	input wire logic lockout
);
	// Modes: 0 read, 1 program, 2 timeout, 3 abort, 4 erase, 5 suspend-read, 6 suspend-program
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] st_q = 3'h0;
	logic [7:0] left_q = 8'h00;
	logic tgl_q = 1'b0;
	logic win_q = 1'b0;
	logic ok_q = 1'b0;
	logic [15:0] held_q = 16'h0000;
	logic [15:0] last_wd = 16'h0000;
	logic [21:0] last_wa = 22'h0;
	logic [7:0] wcount = 8'h00;
	logic sec_q = 1'b0;
	logic spoil_q = 1'b0;
	wire logic rd = !pins.ce_n && !pins.oe_n;
	wire logic in_sec = (pins.addr[21:15] == 7'h00);
	wire logic prot = (pins.addr[21:15] == 7'h7F);
	wire logic prog = (st_q == 3'h1) || (st_q == 3'h6);
	wire logic erasing = (st_q == 3'h4) || (st_q == 3'h5);
	// Erasing sector scrambled after an interrupted erase
	wire logic [15:0] arr = 16'h3C00 ^ pins.addr[15:0] ^ {16{spoil_q && in_sec}};
	wire logic pol = (st_q == 3'h5) || (prog && !last_wd[7]);
	wire logic busy6 = (st_q == 3'h5) || tgl_q;
	wire logic tgl2 = erasing ? sec_q : 1'b1;
	// Status: polling, busy toggle, timeout, window, sector toggle, abort
	wire logic [15:0] stat = {8'h00, pol, busy6, st_q == 3'h2, 1'b0, win_q, tgl2,
		st_q == 3'h3, 1'b0};
	wire logic [15:0] word = (st_q != 3'h0) ? stat : arr;
	// Released bus shows the inverse of the last word
	assign dq_i = !pins.dq_oe_n ? pins.dq_o : (rd ? word : ~held_q);
	always @(posedge pins.oe_n) begin
		held_q <= word;
		if (st_q != 3'h0 && st_q != 3'h5)
			tgl_q <= ~tgl_q;
		if (erasing && in_sec)
			sec_q <= ~sec_q;
		if (st_q == 3'h1) begin
			left_q <= left_q - 8'h01;
			if (left_q == 8'h01)
				st_q <= 3'h0;
		end
	end
	always @(negedge pins.we_n) ok_q <= !pins.ce_n && pins.oe_n;
	always @(posedge pins.we_n or posedge arm or posedge lockout) begin
		if (lockout) begin
			// Low supply: back to read mode, writes dropped
			spoil_q <= spoil_q || (st_q == 3'h4);
			st_q <= 3'h0;
		end else if (arm) begin
			st_q <= mode;
			left_q <= cnt;
			win_q <= 1'b0;
		end else if (ok_q) begin
			wcount <= wcount + 8'h01;
			// Protected sector keeps its contents
			if (!prot) begin
				last_wd <= pins.dq_o;
				last_wa <= pins.addr;
			end
			if (st_q == 3'h4 && !prot)
				win_q <= 1'b1;
			if (pins.dq_o == fsfwg_pkg::CMD_RESET)
				st_q <= 3'h0;
		end
	end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the flash status host
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	fsfwg_pkg::fsfwg_pins_t flash_o;
	logic [15:0] dq_i;
	logic [2:0] mode = 3'h0;
	logic [7:0] cnt = 8'h00;
	logic arm = 1'b0;
	logic lockout = 1'b0;
	int bad_count = 0;
	int checks = 0;
	always #5 mclk = ~mclk;
	fsfwg_host dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_o(flash_o), .dq_i(dq_i));
	fsfwg_flash_model u_flash (.pins(flash_o), .dq_i(dq_i), .mode(mode), .cnt(cnt), .arm(arm),
		.lockout(lockout));
	// ==========
	// Shared tasks
	task automatic end_of_test;
		if (bad_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	task automatic load(input logic [2:0] m, input logic [7:0] c);
		@(posedge mclk);
		mode <= m;
		cnt <= c;
		arm <= 1'b1;
		@(posedge mclk);
		arm <= 1'b0;
	endtask
	task automatic read2(output logic [31:0] a, output logic [31:0] b);
		logic [31:0] s;
		run(32'(fsfwg_pkg::OP_READ), 1'b0, s);
		rd(fsfwg_pkg::OFF_RDATA, a);
		run(32'(fsfwg_pkg::OP_READ), 1'b0, s);
		rd(fsfwg_pkg::OFF_RDATA, b);
	endtask
	task automatic run(input logic [31:0] c, input logic stop, output logic [31:0] s);
		wr(fsfwg_pkg::OFF_STATUS, 32'h0000_0002);
		wr(fsfwg_pkg::OFF_CTRL, c | 32'h0000_0010);
		if (stop)
			wr(fsfwg_pkg::OFF_CTRL, c | 32'h0000_0020);
		do rd(fsfwg_pkg::OFF_STATUS, s); while (s[1] !== 1'b1);
	endtask
	// ==========
	// Scenarios
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		rd(fsfwg_pkg::OFF_CTRL, r);
		chk(r, 32'h0);
		rd(fsfwg_pkg::OFF_STATUS, r);
		chk(r, 32'h0);
		apb(1'b0, 32'h0000_0014, 32'h0, r, e);
		chk({r[30:0], e}, 32'h0000_0001);
	endtask
	task automatic t_rw;
		logic [31:0] s;
		wr(fsfwg_pkg::OFF_ADDR, 32'h0000_0155);
		run(32'(fsfwg_pkg::OP_READ), 1'b0, s);
		rd(fsfwg_pkg::OFF_RDATA, s);
		chk(s, 32'h0000_3D55);
		wr(fsfwg_pkg::OFF_WDATA, 32'h0000_1234);
		run(32'(fsfwg_pkg::OP_WRITE), 1'b0, s);
		chk({u_flash.last_wd, u_flash.last_wa[15:0]}, 32'h1234_0155);
	endtask
	task automatic t_polls;
		logic [31:0] s;
		logic [7:0] n;
		load(3'h1, 8'h05);
		run(32'(fsfwg_pkg::OP_POLL), 1'b0, s);
		chk(s & 32'h2E, 32'h02);
		load(3'h1, 8'hC8);
		run(32'(fsfwg_pkg::OP_POLL), 1'b1, s);
		chk(s & 32'h2E, 32'h22);
		n = u_flash.wcount;
		load(3'h3, 8'h00);
		run(32'(fsfwg_pkg::OP_POLL), 1'b0, s);
		chk(s & 32'h2E, 32'h0A);
		chk({u_flash.last_wd, u_flash.last_wa[15:0]}, 32'h00F0_0555);
		chk(32'(u_flash.wcount - n), 32'h3);
		load(3'h2, 8'h00);
		run(32'(fsfwg_pkg::OP_POLL), 1'b0, s);
		chk(s & 32'h2E, 32'h06);
		chk({u_flash.last_wd, u_flash.last_wa[15:0]}, 32'h00F0_0155);
		chk(32'(u_flash.st_q), 32'h0);
	endtask
	task automatic t_erase;
		logic [31:0] s;
		load(3'h4, 8'h00);
		wr(fsfwg_pkg::OFF_WDATA, 32'h0000_0030);
		run(32'(fsfwg_pkg::OP_ERASE_ADD), 1'b0, s);
		chk(s & 32'h52, 32'h12);
	endtask
	task automatic t_modes;
		logic [31:0] s;
		logic [31:0] a;
		logic [31:0] b;
		logic [7:0] n;
		load(3'h4, 8'h00);
		read2(a, b);
		chk((a ^ b) & 32'h44, 32'h44);
		load(3'h5, 8'h00);
		run(32'(fsfwg_pkg::OP_POLL), 1'b0, s);
		chk(s & 32'h2F, 32'h02);
		rd(fsfwg_pkg::OFF_RDATA, a);
		chk(a & 32'hC0, 32'hC0);
		rd(fsfwg_pkg::OFF_CTRL, a);
		chk(a, 32'h0000_0002);
		wr(fsfwg_pkg::OFF_ADDR, 32'h0000_8000);
		load(3'h6, 8'h00);
		read2(a, b);
		chk(a & 32'h04, 32'h04);
		chk((a ^ b) & 32'h40, 32'h40);
		load(3'h4, 8'h00);
		read2(a, b);
		chk((a ^ b) & 32'h04, 32'h0);
		lockout <= 1'b1;
		n = u_flash.wcount;
		run(32'(fsfwg_pkg::OP_WRITE), 1'b0, s);
		chk(32'(u_flash.wcount - n), 32'h0);
		run(32'(fsfwg_pkg::OP_READ), 1'b0, s);
		rd(fsfwg_pkg::OFF_RDATA, a);
		chk(a, 32'h0000_BC00);
		lockout <= 1'b0;
		a = {u_flash.last_wd, u_flash.last_wa[15:0]};
		wr(fsfwg_pkg::OFF_ADDR, 32'h003F_8000);
		rd(fsfwg_pkg::OFF_ADDR, b);
		chk(b, 32'h003F_8000);
		run(32'(fsfwg_pkg::OP_WRITE), 1'b0, s);
		chk({u_flash.last_wd, u_flash.last_wa[15:0]}, a);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		t_regs;
		t_rw;
		t_polls;
		t_erase;
		t_modes;
		end_of_test;
	end
	initial begin
		#500000;
		bad_count++;
		end_of_test;
	end
endmodule
